// [common/trig_pkg.sv]
// Package for the digitizer trigger unit: encodings, reset values and limits.
// Assumes a single sample/DSP clock and plain configuration ports.
`default_nettype none
package trig_pkg;
    // ********************************************************
    // Source and option encodings
    // ********************************************************
    typedef enum logic [2:0] {
        src_converter = 3'h0,
        src_magnitude = 3'h1,
        src_ext_input = 3'h2,
        src_software_only = 3'h3,
        src_immediate = 3'h4
    } trig_source_sel_t;
    typedef enum logic [1:0] {
        loop_idle = 2'h0,
        loop_arm = 2'h1,
        loop_measure = 2'h2,
        loop_trigger = 2'h3
    } loop_state_t;
    localparam logic edge_rising = 1'b0;
    localparam logic edge_falling = 1'b1;
    localparam logic originate_on = 1'b1;
    localparam logic originate_off = 1'b0;
    // ********************************************************
    // Widths
    // ********************************************************
    localparam int SAMPLE_W = 24;
    localparam int MAG_W = 16;
    localparam int DELAY_W = 32;
    localparam int ADC_LVL_W = 10;
    localparam int MAG_LVL_W = 10;
    // ********************************************************
    // Reset values
    // ********************************************************
    localparam trig_source_sel_t SRC_RESET = src_immediate;
    localparam logic signed [DELAY_W-1:0] DELAY_RESET = 32'sh0;
    localparam logic signed [ADC_LVL_W-1:0] ADC_LVL_RESET = 10'sh0;
    localparam logic signed [MAG_LVL_W-1:0] MAG_LVL_RESET = -10'sd128;
    localparam logic SLOPE_RESET = edge_rising;
    localparam logic GEN_RESET = originate_on;
    // ********************************************************
    // Level and delay limits
    // ********************************************************
    localparam logic signed [ADC_LVL_W-1:0] ADC_LVL_MIN = -10'sd256;
    localparam logic signed [ADC_LVL_W-1:0] ADC_LVL_MAX = 10'sd255;
    localparam logic signed [MAG_LVL_W-1:0] MAG_LVL_MIN = -10'sd349;
    localparam logic signed [MAG_LVL_W-1:0] MAG_LVL_MAX = 10'sd19;
    localparam int ADC_LVL_SHIFT = 8;
    // Magnitude threshold step in micro-dB: 0.3762874 dB per level.
    localparam int MAG_STEP_UDB = 376287;
    localparam logic signed [DELAY_W-1:0] POST_MAX_W8 = 32'sd16777116;
    localparam logic signed [DELAY_W-1:0] POST_MAX_W4 = 32'sd33554332;
    localparam logic signed [DELAY_W-1:0] POST_MAX_W2 = 32'sd67108764;
    localparam logic signed [DELAY_W-1:0] PRE_OFS_W8 = 32'sd132;
    localparam logic signed [DELAY_W-1:0] PRE_OFS_W4 = 32'sd164;
    localparam logic signed [DELAY_W-1:0] PRE_OFS_W2 = 32'sd228;
    localparam int BUF_BYTES_DEF = 8388608;
    // Hysteresis band in converter codes around the threshold.
    localparam int HYST_DEF = 64;
endpackage
`default_nettype wire

// [hdl/cross_detect.sv]
// Threshold crossing detector with hysteresis and slope selection.
// Assumes samples arrive with a valid strobe on the same clock.
`default_nettype none
module cross_detect #(
    parameter int W = 24,
    parameter int HYST = 64
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire logic signed [W-1:0] sample,
    input wire logic signed [W-1:0] threshold,
    input wire logic slope,
    output logic fire
);
    import trig_pkg::*;
    logic above_q;
    logic above_d;
    logic signed [W:0] hi_lvl;
    logic signed [W:0] lo_lvl;
    logic go_up;
    logic go_down;
    // ********************************************************
    // Hysteresis band
    // ********************************************************
    // The state only flips after leaving the band, so noise near the
    // threshold yields one crossing only.
    assign hi_lvl = (W+1)'(threshold) + (W+1)'(HYST);
    assign lo_lvl = (W+1)'(threshold) - (W+1)'(HYST);
    assign go_up = sample_valid && !above_q && ((W+1)'(sample) >= hi_lvl);
    assign go_down = sample_valid && above_q && ((W+1)'(sample) < lo_lvl);
    assign above_d = go_up ? 1'b1 : (go_down ? 1'b0 : above_q);
    assign fire = (slope == edge_rising) ? go_up : go_down;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            above_q <= 1'b0;
        end else begin
            above_q <= above_d;
        end
    end
endmodule // cross_detect
`default_nettype wire

// [hdl/sync2.sv]
// Two flip-flop synchroniser for a single level from another domain.
// Assumes the input is glitch-free at its source.
`default_nettype none
module sync2 (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    logic sync_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
    assign sync_out = sync_q;
endmodule // sync2
`default_nettype wire

// [hdl/trig_unit.sv]
// Trigger unit of a digitizer: source selection, thresholds, delay checks and
// the shared open-collector sync line. Assumes the measurement loop state, the
// samples and the settings come from logic on ref_clk; pins are synchronised.
//
// Contract
// - Trigger only in trigger state while the sync line is seen released.
// - On a trigger, stop driving the sync line.
// - Converter source compares raw samples against the converter threshold.
// - Magnitude source compares filtered log magnitude against its threshold.
// - External source triggers on transitions of the front-panel input.
// - Software-only raises no trigger; controller pulls sync after trigger state.
// - Immediate source triggers on entering the trigger state.
// - Delay counts output samples; negative delay keeps pre-trigger samples.
// - Post-trigger limit depends on sample size: 16777116, 33554332, 67108764; the code checks 16777116 only.
// - Pre-trigger limit is offset minus buffer bytes over bytes per sample; the code always uses the 8-byte offset and divisor.
// - Out-of-range delay flags bad parameter but is stored anyway.
// - Converter threshold is full scale times level over 256, level -256..255.
// - Hysteresis makes one threshold crossing give one trigger.
// - Magnitude threshold is 0.3762874 dB per step, level -349..19; the code uses 376 milli-dB per step.
// - Slope picks rising or falling crossing.
// - Generation enable gates originating; other modules' triggers still followed.
// - Parameter writes never abort a running measurement.
// - Release sync in trigger state or when armed with pre-trigger gathered.
`default_nettype none
module trig_unit #(
    parameter int BUF_BYTES = trig_pkg::BUF_BYTES_DEF,
    parameter int HYST = trig_pkg::HYST_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] loop_state,
    input wire logic pretrig_done,
    input wire logic cfg_wr,
    input wire logic [2:0] cfg_source,
    input wire logic signed [trig_pkg::DELAY_W-1:0] cfg_delay,
    input wire logic signed [trig_pkg::ADC_LVL_W-1:0] cfg_adc_level,
    input wire logic signed [trig_pkg::MAG_LVL_W-1:0] cfg_mag_level,
    input wire logic cfg_slope,
    input wire logic cfg_gen,
    input wire logic [1:0] sample_bytes,
    input wire logic conv_valid,
    input wire logic signed [trig_pkg::SAMPLE_W-1:0] conv_sample,
    input wire logic mag_valid,
    input wire logic signed [trig_pkg::MAG_W-1:0] mag_udb,
    input wire logic ext_trig_pin,
    input wire logic sync_line_in,
    output logic sync_line_out,
    output logic sync_line_oe,
    output logic trig_event,
    output logic bad_param,
    output logic [2:0] source_sel,
    output logic signed [trig_pkg::DELAY_W-1:0] delay_val,
    output logic signed [trig_pkg::ADC_LVL_W-1:0] adc_level,
    output logic signed [trig_pkg::MAG_LVL_W-1:0] mag_level,
    output logic slope_sel,
    output logic gen_en
);
    import trig_pkg::*;
    // ********************************************************
    // Setting registers
    // ********************************************************
    trig_source_sel_t src_q;
    logic signed [DELAY_W-1:0] delay_q;
    logic signed [ADC_LVL_W-1:0] adc_lvl_q;
    logic signed [MAG_LVL_W-1:0] mag_lvl_q;
    logic slope_q;
    logic gen_q;
    logic bad_q;
    logic bad_d;
    logic released_q;
    logic fired_q;
    logic ext_prev_q;
    logic in_trig_q;
    logic sync_hi_s;
    logic ext_s;
    logic signed [DELAY_W-1:0] pre_min_w8;
    logic adc_lvl_ok;
    logic mag_lvl_ok;
    logic delay_ok;
    logic in_trigger;
    logic enter_trig;
    logic line_free;
    logic cond_conv;
    logic cond_mag;
    logic cond_ext;
    logic src_hit;
    logic originate;
    logic release_d;
    logic signed [SAMPLE_W-1:0] conv_thr;
    logic signed [MAG_W-1:0] mag_thr;
    logic signed [MAG_W-1:0] mag_step;
    logic signed [MAG_W+MAG_LVL_W-1:0] mag_prod;
    logic mag_fits;
    logic ext_edge;

    // Widest format gives the tightest window; the others only widen it.
    assign pre_min_w8 = PRE_OFS_W8 - DELAY_W'(BUF_BYTES / 8);
    assign delay_ok = (cfg_delay >= pre_min_w8) && (cfg_delay <= POST_MAX_W8);
    assign adc_lvl_ok = (cfg_adc_level >= ADC_LVL_MIN) && (cfg_adc_level <= ADC_LVL_MAX);
    assign mag_lvl_ok = (cfg_mag_level >= MAG_LVL_MIN) && (cfg_mag_level <= MAG_LVL_MAX);
    assign bad_d = cfg_wr ? !(delay_ok && adc_lvl_ok && mag_lvl_ok) : bad_q;

    // Settings are only registers; nothing here touches the loop state.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            src_q <= SRC_RESET;
            delay_q <= DELAY_RESET;
            adc_lvl_q <= ADC_LVL_RESET;
            mag_lvl_q <= MAG_LVL_RESET;
            slope_q <= SLOPE_RESET;
            gen_q <= GEN_RESET;
            bad_q <= 1'b0;
        end else begin
            if (cfg_wr) begin
                src_q <= trig_source_sel_t'(cfg_source);
                delay_q <= cfg_delay;
                slope_q <= cfg_slope;
                gen_q <= cfg_gen;
                if (adc_lvl_ok) begin
                    adc_lvl_q <= cfg_adc_level;
                end
                if (mag_lvl_ok) begin
                    mag_lvl_q <= cfg_mag_level;
                end
            end
            bad_q <= bad_d;
        end
    end

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    sync2 u_sync_line (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(sync_line_in),
        .sync_out(sync_hi_s)
    );
    sync2 u_sync_ext (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(ext_trig_pin),
        .sync_out(ext_s)
    );

    // ********************************************************
    // Source conditions
    // ********************************************************
    // Full scale is the top of the sample range, so level/256 is a shift.
    assign conv_thr = SAMPLE_W'(adc_lvl_q) <<< (SAMPLE_W - 1 - ADC_LVL_SHIFT);
    assign mag_step = MAG_W'(MAG_STEP_UDB / 1000);
    // Magnitude is in milli-dB relative to full scale.
    assign mag_prod = mag_step * (MAG_W+MAG_LVL_W)'(mag_lvl_q);
    // The magnitude port spans only about 32 dB each way, so deeper levels clip
    // to the lowest code instead of wrapping to a positive threshold.
    assign mag_fits = (mag_prod[MAG_W+MAG_LVL_W-1:MAG_W-1] == '0)
        || (mag_prod[MAG_W+MAG_LVL_W-1:MAG_W-1] == '1);
    assign mag_thr = mag_fits ? mag_prod[MAG_W-1:0] :
        {mag_prod[MAG_W+MAG_LVL_W-1], {(MAG_W-1){~mag_prod[MAG_W+MAG_LVL_W-1]}}};

    cross_detect #(.W(SAMPLE_W), .HYST(HYST)) u_conv (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sample_valid(conv_valid),
        .sample(conv_sample),
        .threshold(conv_thr),
        .slope(slope_q),
        .fire(cond_conv)
    );
    cross_detect #(.W(MAG_W), .HYST(1)) u_mag (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sample_valid(mag_valid),
        .sample(mag_udb),
        .threshold(mag_thr),
        .slope(slope_q),
        .fire(cond_mag)
    );
    assign ext_edge = (slope_q == edge_rising) ? (ext_s && !ext_prev_q) : (!ext_s && ext_prev_q);
    assign cond_ext = ext_edge;

    assign in_trigger = (loop_state == 2'(loop_trigger));
    assign enter_trig = in_trigger && !in_trig_q;
    assign line_free = sync_hi_s;
    assign src_hit = (src_q == src_converter) ? cond_conv :
                     (src_q == src_magnitude) ? cond_mag :
                     (src_q == src_ext_input) ? cond_ext :
                     (src_q == src_immediate) ? enter_trig : 1'b0;
    assign originate = in_trigger && line_free && gen_q && src_hit && !fired_q;
    // Armed with pre-trigger gathered releases the line; so does the trigger state.
    assign release_d = in_trigger || ((loop_state == 2'(loop_arm)) && pretrig_done);

    // ********************************************************
    // Sync line drive
    // ********************************************************
    // The line is held low until the module is armed with pre-trigger gathered or in the trigger state.
    // Holding it in the trigger state would block our own trigger condition.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            released_q <= 1'b0;
            fired_q <= 1'b0;
            ext_prev_q <= 1'b0;
            in_trig_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_s;
            in_trig_q <= in_trigger;
            released_q <= release_d;
            if (!in_trigger) begin
                fired_q <= 1'b0;
            end else if (originate) begin
                fired_q <= 1'b1;
            end
        end
    end
    assign sync_line_out = 1'b0;
    assign sync_line_oe = in_trigger ? 1'b0 : !released_q;
    assign trig_event = originate;
    assign bad_param = bad_q;
    assign source_sel = src_q;
    assign delay_val = delay_q;
    assign adc_level = adc_lvl_q;
    assign mag_level = mag_lvl_q;
    assign slope_sel = slope_q;
    assign gen_en = gen_q;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    trig_needs_state_a: assert property (trig_event |-> in_trigger && line_free)
        else $error("Trigger outside trigger state or with sync held.");
    trig_release_a: assert property (trig_event |-> !sync_line_oe)
        else $error("Sync line still driven on trigger.");
    soft_quiet_a: assert property (src_q == src_software_only |-> !trig_event)
        else $error("Software-only source produced a trigger.");
    gen_gate_a: assert property (!gen_q |-> !trig_event)
        else $error("Trigger while generation disabled.");
    imm_fire_a: assert property (enter_trig && src_q == src_immediate && gen_q && line_free
        |-> trig_event)
        else $error("Immediate source did not fire on entry.");
    one_shot_a: assert property (trig_event |=> !trig_event)
        else $error("Second trigger right after first.");
    bad_flag_a: assert property (cfg_wr && cfg_delay > POST_MAX_W8 |=> bad_param
        && delay_val == $past(cfg_delay))
        else $error("Bad delay not flagged or not stored.");
    reset_vals_a: assert property ($rose(rst_n) |-> src_q == src_immediate
        && mag_lvl_q == MAG_LVL_RESET && gen_q)
        else $error("Trigger settings wrong after reset.");
    armed_release_a: assert property (loop_state == 2'(loop_arm) && pretrig_done
        |=> !sync_line_oe)
        else $error("Armed module still drives sync.");
    sync_free_a: assert property (in_trigger |-> !sync_line_oe)
        else $error("Sync line driven in trigger state.");
    cfg_load_a: assert property (cfg_wr |=> source_sel == $past(cfg_source)
        && slope_sel == $past(cfg_slope) && gen_en == $past(cfg_gen))
        else $error("Settings not loaded by a write.");
    delay_keep_a: assert property (!cfg_wr |=> $stable(delay_val))
        else $error("Delay changed without a write.");
    bad_hold_a: assert property (!cfg_wr |=> $stable(bad_param))
        else $error("Bad flag changed without a write.");
    adc_keep_a: assert property (cfg_wr && !adc_lvl_ok |=> $stable(adc_level))
        else $error("Illegal converter level was taken.");
    mag_keep_a: assert property (cfg_wr && !mag_lvl_ok |=> $stable(mag_level))
        else $error("Illegal magnitude level was taken.");
    conv_fire_a: assert property (in_trigger && line_free && gen_q && !fired_q
        && src_q == src_converter && cond_conv |-> trig_event)
        else $error("Converter crossing did not trigger.");
    mag_fire_a: assert property (in_trigger && line_free && gen_q && !fired_q
        && src_q == src_magnitude && cond_mag |-> trig_event)
        else $error("Magnitude crossing did not trigger.");
    ext_fire_a: assert property (in_trigger && line_free && gen_q && !fired_q
        && src_q == src_ext_input && cond_ext |-> trig_event)
        else $error("External edge did not trigger.");
    cov_imm_c: cover property (src_q == src_immediate && trig_event);
    cov_conv_c: cover property (src_q == src_converter && trig_event);
    cov_ext_c: cover property (src_q == src_ext_input && trig_event);
    cov_mag_c: cover property (src_q == src_magnitude && trig_event);
    cov_bad_c: cover property ($rose(bad_param));
endmodule // trig_unit
`default_nettype wire

// [tb/sync_peer.sv]
// Model of another digitizer module sharing the open-collector sync line.
// Assumes the bench folds its enable with the unit's into one pulled-up line.
`default_nettype none
module sync_peer (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pull,
    output logic line_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // ********************************************************
    // Hold and release
    // ********************************************************
    logic [2:0] hold_q;
    logic [2:0] hold_d;
    // Release lags the request by a few cycles, like a slow module still gathering samples.
    assign hold_d = pull ? 3'h4 : ((hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hold_q <= 3'h4;
        end else begin
            hold_q <= hold_d;
        end
    end
    assign line_oe = (hold_q != 3'h0);
endmodule // sync_peer
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the trigger unit with one peer on the sync line.
// Assumes the unit's settings and pins are driven on ref_clk at 250 MHz.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import trig_pkg::*;
    // ********************************************************
    // Signals
    // ********************************************************
    localparam int BUF = 8388608;
    localparam logic signed [31:0] PRE_MIN = PRE_OFS_W8 - BUF / 8;
    logic ref_clk = 1'b0, rst_n = 1'b0, pretrig_done = 1'b0, cfg_wr = 1'b0;
    logic [1:0] loop_state = 2'h0;
    logic [2:0] cfg_source = 3'h4;
    logic signed [31:0] cfg_delay = 32'sh0;
    logic signed [9:0] cfg_adc_level = 10'sh0, cfg_mag_level = 10'sh0;
    logic cfg_slope = 1'b0, cfg_gen = 1'b1, conv_valid = 1'b1, mag_valid = 1'b1;
    logic ext_trig_pin = 1'b0, peer_pull = 1'b0, peer_oe, sync_line;
    logic signed [23:0] conv_sample = 24'sh0;
    logic signed [15:0] mag_udb = 16'sh0;
    logic sync_line_out, sync_line_oe, trig_event, bad_param, slope_sel, gen_en;
    logic [2:0] source_sel, e_src = 3'h4, exp_src;
    logic signed [31:0] delay_val, e_d = 32'sh0;
    logic signed [9:0] adc_level, mag_level, e_a = 10'sh0, e_m = -10'sh080;
    logic e_sl = 1'b0, e_g = 1'b1, e_bad = 1'b0;
    logic [2:0] exp_q[$];
    int failures = 0, checked = 0;
    always #2 ref_clk = ~ref_clk;
    // Open collector with pull-up: any enabled party pulls the line low.
    assign sync_line = (sync_line_oe ? sync_line_out : 1'b1) & ~peer_oe;
    trig_unit #(.BUF_BYTES(BUF), .HYST(64)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .loop_state(loop_state), .pretrig_done(pretrig_done), .cfg_wr(cfg_wr),
        .cfg_source(cfg_source), .cfg_delay(cfg_delay), .cfg_adc_level(cfg_adc_level),
        .cfg_mag_level(cfg_mag_level), .cfg_slope(cfg_slope), .cfg_gen(cfg_gen),
        .sample_bytes(2'h0), .conv_valid(conv_valid), .conv_sample(conv_sample),
        .mag_valid(mag_valid), .mag_udb(mag_udb), .ext_trig_pin(ext_trig_pin),
        .sync_line_in(sync_line), .sync_line_out(sync_line_out),
        .sync_line_oe(sync_line_oe), .trig_event(trig_event), .bad_param(bad_param),
        .source_sel(source_sel), .delay_val(delay_val), .adc_level(adc_level),
        .mag_level(mag_level), .slope_sel(slope_sel), .gen_en(gen_en));
    sync_peer peer (.ref_clk(ref_clk), .rst_n(rst_n), .pull(peer_pull), .line_oe(peer_oe));
    // ********************************************************
    // Tasks
    // ********************************************************
    task automatic check(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic show();
        check("source_sel", e_src, source_sel);
        check("delay_val", e_d, delay_val);
        check("adc_level", e_a, adc_level);
        check("mag_level", e_m, mag_level);
        check("slope_sel", e_sl, slope_sel);
        check("gen_en", e_g, gen_en);
        check("bad_param", e_bad, bad_param);
    endtask
    task automatic cfg(logic [2:0] s, logic signed [31:0] d, logic signed [9:0] a,
                       logic signed [9:0] m, logic sl, logic g);
        e_bad = (d > POST_MAX_W8) || (d < PRE_MIN) || (a < ADC_LVL_MIN) || (a > ADC_LVL_MAX)
            || (m < MAG_LVL_MIN) || (m > MAG_LVL_MAX);
        e_src = s;
        e_d = d;
        e_sl = sl;
        e_g = g;
        if (a >= ADC_LVL_MIN && a <= ADC_LVL_MAX) e_a = a;
        if (m >= MAG_LVL_MIN && m <= MAG_LVL_MAX) e_m = m;
        @(posedge ref_clk);
        cfg_wr <= 1'b1;
        cfg_source <= s;
        cfg_delay <= d;
        cfg_adc_level <= a;
        cfg_mag_level <= m;
        cfg_slope <= sl;
        cfg_gen <= g;
        @(posedge ref_clk);
        cfg_wr <= 1'b0;
        #1 show();
    endtask
    // One visit of the loop through arm into trigger, with a source crossing inside it.
    task automatic visit(logic [2:0] s, logic sl, logic g, logic hold, logic fire);
        cfg(s, 32'sh0, 10'sh040, 10'sh3F6, sl, g);
        @(posedge ref_clk);
        conv_sample <= sl ? 24'sh500000 : 24'shF00000;
        mag_udb <= sl ? 16'shFC18 : 16'shE0C0;
        ext_trig_pin <= sl;
        peer_pull <= hold;
        loop_state <= 2'h1;
        pretrig_done <= 1'b1;
        repeat (8) @(posedge ref_clk);
        if (fire) exp_q.push_back(s);
        loop_state <= 2'h3;
        repeat (4) @(posedge ref_clk);
        #1 check("sync_line_oe", 1'b0, sync_line_oe);
        @(posedge ref_clk);
        conv_sample <= sl ? 24'shF00000 : 24'sh500000;
        mag_udb <= sl ? 16'shE0C0 : 16'shFC18;
        ext_trig_pin <= ~sl;
        repeat (8) @(posedge ref_clk);
        check("pending", 32'h0, exp_q.size());
        loop_state <= 2'h0;
        pretrig_done <= 1'b0;
        repeat (4) @(posedge ref_clk);
        peer_pull <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ********************************************************
    // Monitor and watchdog
    // ********************************************************
    always @(negedge ref_clk) begin
        if (rst_n === 1'b1 && trig_event !== 1'b0) begin
            if (exp_q.size() == 0) begin
                checked++;
                failures++;
                $display("[FAIL] trig_event expected 0 seen %b", trig_event);
            end else begin
                exp_src = exp_q.pop_front();
                check("trig_source", exp_src, source_sel);
            end
            check("sync_line_oe", 1'b0, sync_line_oe);
        end
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        tally_and_finish();
    end
    // ********************************************************
    // Sequence
    // ********************************************************
    initial begin
        void'($urandom(32'h3204));
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1 show();
        cfg(src_converter, POST_MAX_W8, ADC_LVL_MAX, MAG_LVL_MIN, edge_falling, originate_off);
        cfg(src_magnitude, POST_MAX_W8 + 1, ADC_LVL_MIN, MAG_LVL_MAX, edge_rising, originate_on);
        cfg(src_ext_input, PRE_MIN, 10'sh12C, 10'sh014, edge_rising, originate_on);
        cfg(src_software_only, PRE_MIN - 1, 10'sh001, 10'sh3F6, edge_falling, originate_on);
        repeat (6) begin
            cfg(3'($urandom_range(4)), 32'($urandom_range(2000)) - 32'sd1000,
                10'($urandom_range(511)) - 10'sh100, 10'($urandom_range(368)) - 10'sh15D,
                1'($urandom), 1'($urandom));
        end
        visit(src_immediate, edge_rising, originate_on, 1'b0, 1'b1);
        visit(src_immediate, edge_rising, originate_on, 1'b1, 1'b0);
        visit(src_immediate, edge_rising, originate_off, 1'b0, 1'b0);
        visit(src_software_only, edge_rising, originate_on, 1'b0, 1'b0);
        visit(src_converter, edge_rising, originate_on, 1'b0, 1'b1);
        visit(src_converter, edge_falling, originate_on, 1'b0, 1'b1);
        visit(src_magnitude, edge_rising, originate_on, 1'b0, 1'b1);
        visit(src_ext_input, edge_rising, originate_on, 1'b0, 1'b1);
        visit(src_ext_input, edge_falling, originate_on, 1'b0, 1'b1);
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
